// file: hdl/lmc_coil_bank.sv
// coil register bank of the leak monitor, alarms and host watchdog
// Overview of operation
// - protocol coil: 0 selects legacy ascii protocol, 1 selects modbus rtu
// - watchdog mode 1 lets output commands clear timeout, modbus only
// - watchdog enable coil, effective only under modbus rtu
// - writing 1 to sound coil plays a notification sound
// - timeout status coil, write 1 clears it, modbus only
// - reset status reads 1 on first read after power-up, else 0
// - write 1 clears all high latched, adjacent coil all low latched
// - single sensor: leak alarm status coil, write 1 clears latch
// - single sensor: open-wire alarm status coil, write 1 clears latch
// - four sensors: four leak alarm coils, write 1 clears each latch
// - four sensors: four open-wire alarm coils, write 1 clears each
// - live open-wire condition read-only, mirrored in discrete inputs
// - per-sensor leak alarm enables, single variant uses the first
// - open-wire alarm enables, one or four coils by variant
// - per-sensor leak alarm type, momentary or latched
// - open-wire alarm type, one or four coils by variant
// - per-sensor write 1 clears high latched or low latched reading
// - coil holds power-up value of digital output channel 0
// - strap 1 on selects legacy ascii protocol, off modbus rtu
// - strap 2 on takes config from software, off from switches
// - bus address is 96 plus 16 when strap 3 on, else plus 0
// - strap 4 on enters initialisation mode, off normal operation
// - watchdog timeout in tenths of a second, range 0 to 255
// - coil holds safe value of digital output 0 after timeout
module lmc_coil_bank #(
	parameter int unsigned SENSORS      = 4,
	parameter int unsigned TICK_CYCLES  = lmc_pkg::WDT_TICK_CYC
) (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// coil access from the protocol engine
	input  wire lmc_pkg::lmc_coil_req_s coil_req,
	output lmc_pkg::lmc_coil_rsp_s     coil_rsp_ff,
	// sensor conditions and straps
	input  wire logic [3:0]            leak_cond,
	input  wire logic [3:0]            open_cond,
	input  wire logic [3:0]            strap_sw,
	// host watchdog inputs
	input  wire logic                  host_activity,
	input  wire logic                  output_cmd_seen,
	input  wire logic [7:0]            wdt_timeout_val,
	// control and status outputs
	output logic                       protocol_modbus_ff,
	output logic                       cfg_by_software_ff,
	output logic                       init_mode_ff,
	output logic [7:0]                 bus_address_ff,
	output logic                       do0_powerup_ff,
	output logic                       do0_safe_ff,
	output logic                       wdt_timeout_ff,
	output logic                       sound_pulse_ff,
	output logic [3:0]                 leak_alarm_ff,
	output logic [3:0]                 open_alarm_ff,
	output logic [3:0]                 clr_high_pulse_ff,
	output logic [3:0]                 clr_low_pulse_ff
);
	localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

	if (SENSORS != 1 && SENSORS != 4) begin : g_chk
		$error("SENSORS must be 1 or 4");
	end
	if (TICK_CYCLES < 1) begin : g_chk_tick
		$error("TICK_CYCLES must be at least 1");
	end

	// {hit, index} for a group of n coils starting at base
	function automatic logic [2:0] grp(input logic [15:0] a,
		input logic [15:0] base, input int unsigned n);
		logic [15:0] d;
		d = a - base;
		grp = {(a >= base) && (d < 16'(n)), d[1:0]};
	endfunction

	logic rst_meta_ff;
	logic rst_sync_ff;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	localparam int unsigned N = SENSORS;
	logic [15:0] open_alm_base;
	logic [15:0] open_en_base;
	logic [15:0] open_type_base;
	assign open_alm_base  = (N == 1) ? lmc_pkg::C_OPEN_ALM_1 : lmc_pkg::C_OPEN_ALM_4;
	assign open_en_base   = (N == 1) ? lmc_pkg::C_OPEN_EN_1 : lmc_pkg::C_OPEN_EN_4;
	assign open_type_base = (N == 1) ? lmc_pkg::C_OPEN_TYPE_1 : lmc_pkg::C_OPEN_TYPE_4;

	logic [3:0] smask;
	assign smask = (N == 1) ? 4'h1 : 4'hF;

	logic        wr1;
	logic [15:0] a;
	assign wr1 = coil_req.wr && coil_req.wdata;
	assign a   = coil_req.addr;

	logic [2:0] g_leak_alm, g_open_alm, g_leak_en, g_open_en;
	logic [2:0] g_leak_ty, g_open_ty, g_clr_hi, g_clr_lo, g_live;
	assign g_leak_alm = grp(a, lmc_pkg::C_LEAK_ALM, N);
	assign g_open_alm = grp(a, open_alm_base, N);
	assign g_leak_en  = grp(a, lmc_pkg::C_LEAK_EN, N);
	assign g_open_en  = grp(a, open_en_base, N);
	assign g_leak_ty  = grp(a, lmc_pkg::C_LEAK_TYPE, N);
	assign g_open_ty  = grp(a, open_type_base, N);
	assign g_clr_hi   = grp(a, lmc_pkg::C_CLR_HI, N);
	assign g_clr_lo   = grp(a, lmc_pkg::C_CLR_LO, N);
	assign g_live     = grp(a, lmc_pkg::C_OPEN_LIVE, N);

	// one-hot of the addressed sensor for a group hit
	function automatic logic [3:0] sel(input logic [2:0] g);
		sel = g[2] ? (4'h1 << g[1:0]) : 4'h0;
	endfunction

	// selects held in nets, a function result cannot be bit-selected
	logic [3:0] s_leak_en, s_open_en, s_leak_ty, s_open_ty;
	assign s_leak_en = sel(g_leak_en);
	assign s_open_en = sel(g_open_en);
	assign s_leak_ty = sel(g_leak_ty);
	assign s_open_ty = sel(g_open_ty);

	// straps are caught once, in the first cycle after reset release
	logic strap_done_ff;
	always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			strap_done_ff      <= 1'b0;
			cfg_by_software_ff <= 1'b0;
			init_mode_ff       <= 1'b0;
			bus_address_ff     <= lmc_pkg::ADDR_BASE;
		end else if (!strap_done_ff) begin
			strap_done_ff      <= 1'b1;
			cfg_by_software_ff <= strap_sw[lmc_pkg::SW_CONFIG];
			init_mode_ff       <= strap_sw[lmc_pkg::SW_INIT];
			bus_address_ff     <= lmc_pkg::ADDR_BASE +
				(strap_sw[lmc_pkg::SW_ADDR] ? lmc_pkg::ADDR_OFFSET : 8'h00);
		end
	end

	// plain read/write configuration coils
	logic       wdt_mode_ff;
	logic       wdt_en_ff;
	logic [3:0] leak_en_ff, open_en_ff, leak_ty_ff, open_ty_ff;
	always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			protocol_modbus_ff <= 1'b0;
			wdt_mode_ff        <= 1'b0;
			wdt_en_ff          <= 1'b0;
			do0_powerup_ff     <= 1'b0;
			do0_safe_ff        <= 1'b0;
			leak_en_ff         <= 4'h0;
			open_en_ff         <= 4'h0;
			leak_ty_ff         <= 4'h0;
			open_ty_ff         <= 4'h0;
		end else if (!strap_done_ff) begin
			protocol_modbus_ff <= !strap_sw[lmc_pkg::SW_PROTOCOL];
		end else if (coil_req.wr) begin
			if (a == lmc_pkg::C_PROTOCOL)
				protocol_modbus_ff <= coil_req.wdata;
			if (a == lmc_pkg::C_WDT_MODE)
				wdt_mode_ff <= coil_req.wdata;
			if (a == lmc_pkg::C_WDT_EN)
				wdt_en_ff <= coil_req.wdata;
			if (a == lmc_pkg::C_DO0_PWRUP)
				do0_powerup_ff <= coil_req.wdata;
			if (a == lmc_pkg::C_DO0_SAFE)
				do0_safe_ff <= coil_req.wdata;
			for (int i = 0; i < 4; i++) begin
				if (s_leak_en[i])
					leak_en_ff[i] <= coil_req.wdata;
				if (s_open_en[i])
					open_en_ff[i] <= coil_req.wdata;
				if (s_leak_ty[i])
					leak_ty_ff[i] <= coil_req.wdata;
				if (s_open_ty[i])
					open_ty_ff[i] <= coil_req.wdata;
			end
		end
	end

	// write-1 command coils give one-cycle pulses
	always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			sound_pulse_ff    <= 1'b0;
			clr_high_pulse_ff <= 4'h0;
			clr_low_pulse_ff  <= 4'h0;
		end else begin
			sound_pulse_ff <= wr1 && (a == lmc_pkg::C_SOUND);
			clr_high_pulse_ff <= wr1 ? (sel(g_clr_hi) |
				((a == lmc_pkg::C_CLR_ALL_HI) ? smask : 4'h0)) & smask
				: 4'h0;
			clr_low_pulse_ff <= wr1 ? (sel(g_clr_lo) |
				((a == lmc_pkg::C_CLR_ALL_LO) ? smask : 4'h0)) & smask
				: 4'h0;
		end
	end

	// alarms: a raising condition wins over a clear in the same cycle
	logic [3:0] leak_act, open_act, leak_clr, open_clr;
	assign leak_act = leak_cond & leak_en_ff & smask;
	assign open_act = open_cond & open_en_ff & smask;
	assign leak_clr = wr1 ? sel(g_leak_alm) : 4'h0;
	assign open_clr = wr1 ? sel(g_open_alm) : 4'h0;

	for (genvar s = 0; s < 4; s++) begin : g_alm
		always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
			if (!rst_sync_ff) begin
				leak_alarm_ff[s] <= 1'b0;
				open_alarm_ff[s] <= 1'b0;
			end else begin
				if (!leak_ty_ff[s])
					leak_alarm_ff[s] <= leak_act[s];
				else if (leak_act[s])
					leak_alarm_ff[s] <= 1'b1;
				else if (leak_clr[s])
					leak_alarm_ff[s] <= 1'b0;
				if (!open_ty_ff[s])
					open_alarm_ff[s] <= open_act[s];
				else if (open_act[s])
					open_alarm_ff[s] <= 1'b1;
				else if (open_clr[s])
					open_alarm_ff[s] <= 1'b0;
			end
		end
	end

	// host watchdog: tenth-second tick and activity counter
	logic [TW-1:0] tick_cnt_ff;
	logic          tick_ff;
	logic [7:0]    wdt_cnt_ff;
	logic          wdt_run;
	assign wdt_run = wdt_en_ff && protocol_modbus_ff;
	always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end else if (tick_cnt_ff == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + TW'(1);
			tick_ff     <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff)
			wdt_cnt_ff <= 8'h00;
		else if (!wdt_run || host_activity)
			wdt_cnt_ff <= 8'h00;
		else if (tick_ff && wdt_cnt_ff != 8'hFF)
			wdt_cnt_ff <= wdt_cnt_ff + 8'h01;
	end

	// a zero timeout never fires, it would trip on every idle tick
	logic wdt_expire;
	assign wdt_expire = wdt_run && (wdt_timeout_val != 8'h00) &&
		(wdt_cnt_ff >= wdt_timeout_val);

	always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff)
			wdt_timeout_ff <= 1'b0;
		else if (wdt_expire)
			wdt_timeout_ff <= 1'b1;
		else if (protocol_modbus_ff && wr1 && a == lmc_pkg::C_WDT_TIMEOUT)
			wdt_timeout_ff <= 1'b0;
		else if (protocol_modbus_ff && wdt_mode_ff && output_cmd_seen)
			wdt_timeout_ff <= 1'b0;
	end

	// reset status clears on its first read
	logic first_rd_ff;
	always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff)
			first_rd_ff <= 1'b1;
		else if (coil_req.rd && !coil_req.di && a == lmc_pkg::C_FIRST_READ)
			first_rd_ff <= 1'b0;
	end

	// read decode
	logic [3:0] live_open;
	logic       nxt_hit;
	logic       nxt_rdata;
	assign live_open = open_cond & smask;
	always_comb begin
		nxt_hit   = 1'b1;
		nxt_rdata = 1'b0;
		if (coil_req.di) begin
			nxt_hit = g_live[2];
			nxt_rdata = |(sel(g_live) & live_open);
		end else if (g_live[2])
			nxt_rdata = |(sel(g_live) & live_open);
		else if (g_leak_alm[2])
			nxt_rdata = |(sel(g_leak_alm) & leak_alarm_ff);
		else if (g_open_alm[2])
			nxt_rdata = |(sel(g_open_alm) & open_alarm_ff);
		else if (g_leak_en[2])
			nxt_rdata = |(sel(g_leak_en) & leak_en_ff);
		else if (g_open_en[2])
			nxt_rdata = |(sel(g_open_en) & open_en_ff);
		else if (g_leak_ty[2])
			nxt_rdata = |(sel(g_leak_ty) & leak_ty_ff);
		else if (g_open_ty[2])
			nxt_rdata = |(sel(g_open_ty) & open_ty_ff);
		else if (g_clr_hi[2] || g_clr_lo[2])
			nxt_rdata = 1'b0;
		else begin
			unique case (a)
				lmc_pkg::C_DO0_SAFE:    nxt_rdata = do0_safe_ff;
				lmc_pkg::C_DO0_PWRUP:   nxt_rdata = do0_powerup_ff;
				lmc_pkg::C_PROTOCOL:    nxt_rdata = protocol_modbus_ff;
				lmc_pkg::C_WDT_MODE:    nxt_rdata = wdt_mode_ff;
				lmc_pkg::C_WDT_EN:      nxt_rdata = wdt_en_ff;
				lmc_pkg::C_WDT_TIMEOUT: nxt_rdata = wdt_timeout_ff;
				lmc_pkg::C_FIRST_READ:  nxt_rdata = first_rd_ff;
				lmc_pkg::C_SOUND,
				lmc_pkg::C_CLR_ALL_HI,
				lmc_pkg::C_CLR_ALL_LO:  nxt_rdata = 1'b0;
				default:                nxt_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			coil_rsp_ff <= '0;
		end else begin
			coil_rsp_ff.ack   <= coil_req.rd || coil_req.wr;
			coil_rsp_ff.hit   <= (coil_req.rd || coil_req.wr) && nxt_hit;
			coil_rsp_ff.rdata <= coil_req.rd && nxt_rdata;
		end
	end
endmodule // lmc_coil_bank

// file: hdl/lmc_pkg.sv
// constants, types and coil map of the leak monitor coil bank
package lmc_pkg;
	localparam int unsigned CA_W = 16;
	localparam int unsigned NSENS_MAX = 4;

	// coil numbers (base 1)
	localparam logic [15:0] C_DO0_SAFE     = 16'h0081;
	localparam logic [15:0] C_DO0_PWRUP    = 16'h00A1;
	localparam logic [15:0] C_OPEN_LIVE    = 16'h00E1;
	localparam logic [15:0] C_PROTOCOL     = 16'h0101;
	localparam logic [15:0] C_WDT_MODE     = 16'h0104;
	localparam logic [15:0] C_WDT_EN       = 16'h0105;
	localparam logic [15:0] C_SOUND        = 16'h0106;
	localparam logic [15:0] C_WDT_TIMEOUT  = 16'h010E;
	localparam logic [15:0] C_FIRST_READ   = 16'h0111;
	localparam logic [15:0] C_CLR_ALL_HI   = 16'h0118;
	localparam logic [15:0] C_CLR_ALL_LO   = 16'h0119;
	localparam logic [15:0] C_LEAK_ALM     = 16'h0121;
	localparam logic [15:0] C_OPEN_ALM_1   = 16'h0122;
	localparam logic [15:0] C_OPEN_ALM_4   = 16'h0125;
	localparam logic [15:0] C_LEAK_EN      = 16'h0141;
	localparam logic [15:0] C_OPEN_EN_1    = 16'h0142;
	localparam logic [15:0] C_OPEN_EN_4    = 16'h0145;
	localparam logic [15:0] C_LEAK_TYPE    = 16'h0151;
	localparam logic [15:0] C_OPEN_TYPE_1  = 16'h0152;
	localparam logic [15:0] C_OPEN_TYPE_4  = 16'h0155;
	localparam logic [15:0] C_CLR_HI       = 16'h0181;
	localparam logic [15:0] C_CLR_LO       = 16'h01A1;

	// strap switch positions, switch n at bit n-1, ON reads 1
	localparam int unsigned SW_PROTOCOL = 0;
	localparam int unsigned SW_CONFIG   = 1;
	localparam int unsigned SW_ADDR     = 2;
	localparam int unsigned SW_INIT     = 3;

	localparam logic [7:0] ADDR_BASE   = 8'h60;
	localparam logic [7:0] ADDR_OFFSET = 8'h10;

	// watchdog unit of 0.1 s
	localparam longint unsigned WDT_UNIT_NS = 100_000_000;
	localparam longint unsigned CLK_NS      = 40;
	localparam int unsigned WDT_TICK_CYC = int'(WDT_UNIT_NS / CLK_NS);

	typedef struct packed {
		logic            rd;    // read strobe, one cycle
		logic            wr;    // write strobe, one cycle
		logic            di;    // read targets discrete-input space
		logic [CA_W-1:0] addr;  // coil number
		logic            wdata; // coil value written
	} lmc_coil_req_s;

	typedef struct packed {
		logic ack;   // one-cycle answer
		logic hit;   // address mapped
		logic rdata; // coil value read
	} lmc_coil_rsp_s;
endpackage : lmc_pkg

// file: test/lmc_coil_bank_checker.sv
// port-level assertions for the leak monitor coil bank
module lmc_coil_bank_checker (
	// clock and reset
	input wire logic                   sys_clk,
	input wire logic                   rst_b,
	// coil port and straps
	input wire lmc_pkg::lmc_coil_req_s coil_req,
	input wire lmc_pkg::lmc_coil_rsp_s coil_rsp_ff,
	input wire logic [3:0]             strap_sw,
	// outputs watched
	input wire logic                   protocol_modbus_ff,
	input wire logic                   cfg_by_software_ff,
	input wire logic                   init_mode_ff,
	input wire logic [7:0]             bus_address_ff,
	input wire logic                   sound_pulse_ff,
	input wire logic [3:0]             clr_high_pulse_ff,
	input wire logic [3:0]             clr_low_pulse_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	// edges since release; straps land on the third
	logic [2:0] up_cnt_ff;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			up_cnt_ff <= 3'h0;
		else if (up_cnt_ff != 3'h7)
			up_cnt_ff <= up_cnt_ff + 3'h1;
	end
	sequence s_req;
		coil_req.rd || coil_req.wr;
	endsequence
	sequence s_wr1(logic [15:0] a);
		coil_req.wr && coil_req.addr == a && coil_req.wdata;
	endsequence
	a_ack_next: assert property (s_req |=> coil_rsp_ff.ack)
		else $error("no ack after request");
	a_ack_idle: assert property (!coil_req.rd && !coil_req.wr |=>
		!coil_rsp_ff.ack) else $error("ack without request");
	a_sound_pulse: assert property (
		s_wr1(lmc_pkg::C_SOUND) |=> sound_pulse_ff)
		else $error("sound pulse missing");
	a_sound_quiet: assert property (
		!coil_req.wr |=> !sound_pulse_ff) else $error("stray sound pulse");
	a_clear_all_hi: assert property (
		s_wr1(lmc_pkg::C_CLR_ALL_HI) |=> clr_high_pulse_ff == 4'hF)
		else $error("clear all high pulse wrong");
	a_clear_all_lo: assert property (
		s_wr1(lmc_pkg::C_CLR_ALL_LO) |=> clr_low_pulse_ff == 4'hF)
		else $error("clear all low pulse wrong");
	a_proto_write: assert property (
		coil_req.wr && coil_req.addr == lmc_pkg::C_PROTOCOL |=>
		protocol_modbus_ff == $past(coil_req.wdata))
		else $error("protocol coil not written");
	a_strap_load: assert property (
		up_cnt_ff == 3'h3 |-> protocol_modbus_ff == !strap_sw[0] &&
		cfg_by_software_ff == strap_sw[1] && init_mode_ff == strap_sw[3]
		&& bus_address_ff == (strap_sw[2] ? 8'h70 : 8'h60))
		else $error("straps not captured");
	a_strap_hold: assert property (
		up_cnt_ff == 3'h7 |-> $stable(cfg_by_software_ff) &&
		$stable(init_mode_ff) && $stable(bus_address_ff))
		else $error("strap outputs moved");
endmodule // lmc_coil_bank_checker

bind lmc_coil_bank lmc_coil_bank_checker lmc_coil_bank_checker_i (
	.sys_clk(sys_clk), .rst_b(rst_b), .coil_req(coil_req),
	.coil_rsp_ff(coil_rsp_ff), .strap_sw(strap_sw),
	.protocol_modbus_ff(protocol_modbus_ff),
	.cfg_by_software_ff(cfg_by_software_ff), .init_mode_ff(init_mode_ff),
	.bus_address_ff(bus_address_ff), .sound_pulse_ff(sound_pulse_ff),
	.clr_high_pulse_ff(clr_high_pulse_ff),
	.clr_low_pulse_ff(clr_low_pulse_ff));

// file: test/lmc_host_model.sv
// host master model driving the coil access port
module lmc_host_model (
	// clock
	input  wire logic                   sys_clk,
	// coil port
	output lmc_pkg::lmc_coil_req_s      coil_req,
	input  wire lmc_pkg::lmc_coil_rsp_s coil_rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	initial coil_req = '0;
	// idle fields show the inverse, never a stale copy
	task automatic xfer(input logic r, w, di, input logic [15:0] a,
		input logic wd, output logic ack, hit, rdat);
		@(posedge sys_clk);
		coil_req <= '{rd: r, wr: w, di: di, addr: a, wdata: wd};
		@(posedge sys_clk);
		coil_req <= '{rd: 1'b0, wr: 1'b0, di: ~di, addr: ~a, wdata: ~wd};
		#1;
		ack = coil_rsp.ack;
		hit = coil_rsp.hit;
		rdat = coil_rsp.rdata;
	endtask
endmodule // lmc_host_model

// file: test/tb_lmc_coil_bank.sv
// self-checking bench for the leak monitor coil bank
module tb_lmc_coil_bank;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   sys_clk, rst_b, host_activity, output_cmd_seen;
	logic [3:0]             leak_cond, open_cond, strap_sw;
	logic [7:0]             wdt_timeout_val, bus_addr;
	lmc_pkg::lmc_coil_req_s coil_req;
	lmc_pkg::lmc_coil_rsp_s coil_rsp;
	logic                   modbus, cfg_sw, init_md, do0_pu, do0_sf;
	logic                   wdt_to, sound, k, h, d;
	logic [3:0]             leak_alm, open_alm, clr_hi, clr_lo;
	logic [15:0]            rw_tab [11] = '{16'h00A1, 16'h0081, 16'h0104,
		16'h0141, 16'h0144, 16'h0145, 16'h0148, 16'h0151, 16'h0154,
		16'h0155, 16'h0158};
	int miscompares = 0, n_compared = 0, cycles = 0;
	lmc_coil_bank #(.SENSORS(4), .TICK_CYCLES(4)) lmc_coil_bank_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .coil_req(coil_req),
		.coil_rsp_ff(coil_rsp), .leak_cond(leak_cond), .open_cond(open_cond),
		.strap_sw(strap_sw), .host_activity(host_activity),
		.output_cmd_seen(output_cmd_seen), .wdt_timeout_val(wdt_timeout_val),
		.protocol_modbus_ff(modbus), .cfg_by_software_ff(cfg_sw),
		.init_mode_ff(init_md), .bus_address_ff(bus_addr),
		.do0_powerup_ff(do0_pu), .do0_safe_ff(do0_sf), .wdt_timeout_ff(wdt_to),
		.sound_pulse_ff(sound), .leak_alarm_ff(leak_alm),
		.open_alarm_ff(open_alm), .clr_high_pulse_ff(clr_hi),
		.clr_low_pulse_ff(clr_lo));
	lmc_host_model lmc_host_model_i (.sys_clk(sys_clk), .coil_req(coil_req),
		.coil_rsp(coil_rsp));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(logic [15:0] a, logic v);
		lmc_host_model_i.xfer(1'b0, 1'b1, 1'b0, a, v, k, h, d);
		chk("write ack", 8'h01, 8'(k));
	endtask
	task automatic rd(logic [15:0] a, logic di, logic eh, logic ed);
		lmc_host_model_i.xfer(1'b1, 1'b0, di, a, 1'b0, k, h, d);
		chk("read ack", 8'h01, 8'(k));
		chk("read hit", 8'(eh), 8'(h));
		chk("read data", 8'(ed), 8'(d));
	endtask
	task automatic do_reset(logic [3:0] s);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		strap_sw <= s;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		step(4);
	endtask
	task automatic pulse(logic a, logic o);
		@(posedge sys_clk);
		host_activity <= a;
		output_cmd_seen <= o;
		@(posedge sys_clk);
		host_activity <= 1'b0;
		output_cmd_seen <= 1'b0;
		step(1);
	endtask
	task automatic wait_to();
		repeat (40) if (wdt_to !== 1'b1) step(1);
		chk("watchdog timeout", 8'h01, 8'(wdt_to));
	endtask
	task automatic cond(int s, logic ow, logic v);
		@(posedge sys_clk);
		if (ow) open_cond[s] <= v;
		else leak_cond[s] <= v;
		step(2);
	endtask
	// one sensor: momentary, latched, then disabled
	task automatic alarm_case(logic [15:0] en, ty, st, int s, logic ow);
		wr(en, 1'b1);
		wr(ty, 1'b0);
		cond(s, ow, 1'b1);
		chk("momentary alarm", 8'h01, 8'(ow ? open_alm[s] : leak_alm[s]));
		rd(st, 1'b0, 1'b1, 1'b1);
		if (ow) rd(16'(lmc_pkg::C_OPEN_LIVE + s), 1'b1, 1'b1, 1'b1);
		if (ow) rd(16'(lmc_pkg::C_OPEN_LIVE + s), 1'b0, 1'b1, 1'b1);
		cond(s, ow, 1'b0);
		chk("momentary drop", 8'h00, 8'(ow ? open_alm[s] : leak_alm[s]));
		wr(ty, 1'b1);
		cond(s, ow, 1'b1);
		cond(s, ow, 1'b0);
		wr(st, 1'b0);
		chk("latched hold", 8'h01, 8'(ow ? open_alm[s] : leak_alm[s]));
		wr(st, 1'b1);
		step(1);
		chk("latched clear", 8'h00, 8'(ow ? open_alm[s] : leak_alm[s]));
		wr(en, 1'b0);
		cond(s, ow, 1'b1);
		chk("disabled alarm", 8'h00, 8'(ow ? open_alm[s] : leak_alm[s]));
		cond(s, ow, 1'b0);
		wr(ty, 1'b0);
	endtask
	initial begin
		rst_b = 1'b0;
		host_activity = 1'b0;
		output_cmd_seen = 1'b0;
		leak_cond = 4'h0;
		open_cond = 4'h0;
		strap_sw = 4'h4;
		wdt_timeout_val = 8'h02;
		do_reset(4'h4);
		chk("straps", 8'h79, {bus_addr[7:4], modbus, cfg_sw, init_md, 1'b1});
		rd(lmc_pkg::C_FIRST_READ, 1'b0, 1'b1, 1'b1);
		rd(lmc_pkg::C_FIRST_READ, 1'b0, 1'b1, 1'b0);
		rd(lmc_pkg::C_PROTOCOL, 1'b0, 1'b1, 1'b1);
		$display("test straps done");
		foreach (rw_tab[i]) begin
			rd(rw_tab[i], 1'b0, 1'b1, 1'b0);
			wr(rw_tab[i], 1'b1);
			rd(rw_tab[i], 1'b0, 1'b1, 1'b1);
			wr(rw_tab[i], 1'b0);
			rd(rw_tab[i], 1'b0, 1'b1, 1'b0);
		end
		wr(lmc_pkg::C_DO0_PWRUP, 1'b1);
		chk("do0 power-up", 8'h01, 8'(do0_pu));
		wr(lmc_pkg::C_DO0_SAFE, 1'b1);
		chk("do0 safe", 8'h01, 8'(do0_sf));
		rd(16'h0000, 1'b0, 1'b0, 1'b0);
		rd(16'h0129, 1'b0, 1'b0, 1'b0);
		rd(lmc_pkg::C_SOUND, 1'b0, 1'b1, 1'b0);
		$display("test coils done");
		wr(lmc_pkg::C_SOUND, 1'b1);
		chk("sound", 8'h01, 8'(sound));
		wr(lmc_pkg::C_CLR_ALL_HI, 1'b1);
		chk("clear all high", 8'h0F, 8'(clr_hi));
		wr(lmc_pkg::C_CLR_ALL_LO, 1'b1);
		chk("clear all low", 8'h0F, 8'(clr_lo));
		for (int s = 0; s < 4; s++) begin
			wr(16'(lmc_pkg::C_CLR_HI + s), 1'b1);
			chk("clear high", 8'(4'h1 << s), 8'(clr_hi));
			wr(16'(lmc_pkg::C_CLR_LO + s), 1'b1);
			chk("clear low", 8'(4'h1 << s), 8'(clr_lo));
			alarm_case(16'(lmc_pkg::C_LEAK_EN + s), 16'(lmc_pkg::C_LEAK_TYPE + s), 16'(lmc_pkg::C_LEAK_ALM + s), s, 1'b0);
			alarm_case(16'(lmc_pkg::C_OPEN_EN_4 + s), 16'(lmc_pkg::C_OPEN_TYPE_4 + s), 16'(lmc_pkg::C_OPEN_ALM_4 + s), s, 1'b1);
		end
		$display("test alarms done");
		wr(lmc_pkg::C_WDT_EN, 1'b1);
		step(4);
		chk("watchdog early", 8'h00, 8'(wdt_to));
		wait_to();
		rd(lmc_pkg::C_WDT_TIMEOUT, 1'b0, 1'b1, 1'b1);
		wr(lmc_pkg::C_PROTOCOL, 1'b0);
		wr(lmc_pkg::C_WDT_TIMEOUT, 1'b1);
		chk("ascii clear ignored", 8'h01, 8'(wdt_to));
		wr(lmc_pkg::C_PROTOCOL, 1'b1);
		pulse(1'b1, 1'b0);
		wr(lmc_pkg::C_WDT_TIMEOUT, 1'b1);
		step(1);
		chk("timeout cleared", 8'h00, 8'(wdt_to));
		wait_to();
		pulse(1'b0, 1'b1);
		chk("mode 0 command", 8'h01, 8'(wdt_to));
		wr(lmc_pkg::C_WDT_MODE, 1'b1);
		// restart the count first, a pending expiry wins over the clear
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		chk("mode 1 command", 8'h00, 8'(wdt_to));
		wr(lmc_pkg::C_WDT_EN, 1'b0);
		step(16);
		chk("watchdog off", 8'h00, 8'(wdt_to));
		$display("test watchdog done");
		do_reset(4'hB);
		chk("straps", 8'h67, {bus_addr[7:4], modbus, cfg_sw, init_md, 1'b1});
		rd(lmc_pkg::C_FIRST_READ, 1'b0, 1'b1, 1'b1);
		$display("test second reset done");
		end_of_test();
	end
endmodule // tb_lmc_coil_bank
